// ==== hw/bec_map.svh ====
`ifndef BEC_MAP_SVH
`define BEC_MAP_SVH
// ==========================================================
// Stop broadcast cycle
`define BEC_STOP_ADDR 20'h3_FFFE
`define BEC_CPU_SPACE_FC 3'h7
`define BEC_MASK_LSB 8
`define BEC_PRECHARGE_BYTE 8'hFF
// ==========================================================
// Bus monitor periods in clocks, selected by the timeout field
`define BEC_BMT_PERIOD0 7'h08
`define BEC_BMT_PERIOD1 7'h10
`define BEC_BMT_PERIOD2 7'h20
`define BEC_BMT_PERIOD3 7'h40
`define BEC_RESET_MASK 3'h7
`endif

// ==== hw/bec_pkg.sv ====
package bec_pkg;
  // ==========================================================
  // Cycle request from the processor core
  typedef struct packed {
    logic [19:0] addr;
    logic [2:0] fc;
    logic write;
    logic prefetch;
    logic [15:0] wdata;
  } bec_req_t;

  // Address-phase signals held on the pins
  typedef struct packed {
    logic [19:0] addr;
    logic [2:0] fc;
    logic write;
  } bec_bus_t;

  typedef enum logic [2:0] {
    BEC_IDLE = 3'b000,
    BEC_ADDR = 3'b001,
    BEC_WAIT = 3'b010,
    BEC_CHK = 3'b011,
    BEC_HALT = 3'b100,
    BEC_DBL = 3'b101
  } bec_state_t;
endpackage

// ==== hw/bec_bus_monitor.sv ====
`include "bec_map.svh"
module bec_bus_monitor (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic enable_i,
  input wire logic run_i,
  input wire logic [1:0] bus_monitor_timeout_field_i,
  output logic timeout_o
);
  logic [6:0] count_reg;
  logic [6:0] limit;

  // ==========================================================
  // Period select; the longest choice is 64 clocks
  always_comb begin
    unique case (bus_monitor_timeout_field_i)
      2'h0: limit = `BEC_BMT_PERIOD0;
      2'h1: limit = `BEC_BMT_PERIOD1;
      2'h2: limit = `BEC_BMT_PERIOD2;
      2'h3: limit = `BEC_BMT_PERIOD3;
    endcase
  end

  // Counts clocks since address strobe; restarts with every cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_reg <= 7'h00;
      timeout_o <= 1'b0;
    end else if (ce_i) begin
      if (!run_i || !enable_i) begin
        count_reg <= 7'h00;
        timeout_o <= 1'b0;
      end else begin
        count_reg <= count_reg + 7'h01;
        timeout_o <= (count_reg + 7'h01 == limit);
      end
    end
  end
endmodule

// ==== hw/bec_exception_ctrl.sv ====
// Functional notes
// - Stop instruction issues a processor-space write to address 3FFFE.
// - That write carries the interrupt mask; clock control keeps a copy.
// - Stop write shows on pins only while this device owns the bus.
// - Stop write ends by internal acknowledge with fast write timing.
// - Bus error during the stop write is ignored.
// - Stop mode ends on reset or interrupt above the held mask.
// - Bus monitor raises internal bus error when acknowledge never arrives.
// - Acknowledged interrupt without arbitration contention raises internal bus error.
// - Any bus error ends the cycle and leads to exception processing.
// - Acknowledge at S without error or halt ends normally; late halt ignored.
// - Acknowledge and halt held S to S+2 end cycle, then halt.
// - Bus error at S, or with halt at S+2, takes bus error.
// - Bus error is latched at cycle end and acted on after instruction.
// - Errored cycle latches no data; prefetch sees all ones instead.
// - Bus error latch clears when the handler's first instruction runs.
// - Error during exception entry or before first post-reset instruction: double fault.
// - Several errors in one instruction give one exception.
// - Double fault halts at once, drives halt low; only reset restarts.
// - Error once the handler runs is an ordinary bus error.
// - Bus error with halt together acts as bus error alone.
// - Bus monitor period selectable, 64 clocks at most.
// - Cycle ending under halt floats data and idles strobes, holds address.
`include "bec_map.svh"
module bec_exception_ctrl (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic req_valid_i,
  input wire bec_pkg::bec_req_t req_i,
  input wire logic stop_req_i,
  input wire logic [2:0] irq_mask_i,
  input wire logic [2:0] irq_level_i,
  input wire logic bus_granted_away_i,
  input wire logic iack_no_arb_i,
  input wire logic instr_done_i,
  input wire logic exc_start_i,
  input wire logic handler_first_i,
  input wire logic bus_monitor_en_i,
  input wire logic [1:0] bus_monitor_timeout_field_i,
  input wire logic [1:0] data_size_ack_n_i,
  input wire logic autovector_request_n_i,
  input wire logic bus_error_line_n_i,
  input wire logic halt_n_i,
  input wire logic [15:0] data_i,
  output bec_pkg::bec_bus_t bus_o,
  output logic address_strobe_n_o,
  output logic data_strobe_n_o,
  output logic [15:0] data_o,
  output logic data_oe_o,
  output logic halt_n_o,
  output logic halt_oe_o,
  output logic ready_o,
  output logic done_o,
  output logic done_bus_error_line_o,
  output logic [15:0] rdata_o,
  output logic bus_error_line_latch_o,
  output logic bus_error_line_exc_o,
  output logic stop_mode_o,
  output logic [2:0] stop_mask_o,
  output logic double_fault_o
);
  import bec_pkg::*;

  bec_state_t state_reg;
  bec_state_t state_next;
  logic stop_cyc_reg;
  logic shown_reg;
  logic prefetch_reg;
  logic halt_s_reg;
  logic exc_busy_reg;
  logic post_reset_reg;
  logic mon_timeout;
  logic ack_in;
  logic halt_in;
  logic bus_error_line_in;
  logic end_ok;
  logic end_bus_error_line;
  logic end_halt;
  logic cyc_end;

  // ==========================================================
  // Termination decode
  // Pins are active low and already synchronous to the clock
  assign ack_in = ~&data_size_ack_n_i | ~autovector_request_n_i;
  assign halt_in = ~halt_n_i;
  // Internal errors join the pin; none counts during the stop write
  assign bus_error_line_in = !stop_cyc_reg
    && (~bus_error_line_n_i || mon_timeout || iack_no_arb_i);

  // Sampled at S: error wins over acknowledge and halt
  // Sampled at S+2: error with halt still ends in error
  assign end_bus_error_line = (state_reg == BEC_WAIT && bus_error_line_in)
    || (state_reg == BEC_CHK && bus_error_line_in && halt_in);
  assign end_halt = state_reg == BEC_CHK && halt_s_reg && halt_in && !bus_error_line_in;
  assign end_ok = (state_reg == BEC_CHK && !end_bus_error_line && !end_halt)
    || (state_reg == BEC_ADDR && stop_cyc_reg);
  assign cyc_end = end_ok || end_bus_error_line || end_halt;

  bec_bus_monitor u_monitor (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .enable_i(bus_monitor_en_i),
    .run_i(state_reg == BEC_ADDR || state_reg == BEC_WAIT),
    .bus_monitor_timeout_field_i(bus_monitor_timeout_field_i),
    .timeout_o(mon_timeout)
  );

  // ==========================================================
  // Bus state machine
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      BEC_IDLE: begin
        if (stop_req_i || req_valid_i) begin
          state_next = BEC_ADDR;
        end
      end
      BEC_ADDR: begin
        state_next = stop_cyc_reg ? BEC_IDLE : BEC_WAIT;
      end
      BEC_WAIT: begin
        if (bus_error_line_in) begin
          state_next = BEC_IDLE;
        end else if (ack_in) begin
          state_next = BEC_CHK;
        end
      end
      BEC_CHK: begin
        state_next = end_halt ? BEC_HALT : BEC_IDLE;
      end
      BEC_HALT: begin
        if (!halt_in) begin
          state_next = BEC_IDLE;
        end
      end
      BEC_DBL: begin
        state_next = BEC_DBL;
      end
      default: begin
        state_next = BEC_IDLE;
      end
    endcase
    // A double fault overrides whatever the cycle would do next
    if (end_bus_error_line && (exc_busy_reg || post_reset_reg)) begin
      state_next = BEC_DBL;
    end
  end

  // Requests are taken only while idle and not stopped
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= BEC_IDLE;
    end else if (ce_i) begin
      if (state_reg == BEC_IDLE && stop_mode_o) begin
        state_reg <= BEC_IDLE;
      end else begin
        state_reg <= state_next;
      end
    end
  end

  assign halt_n_o = 1'b0;

  // ==========================================================
  // Pin drive: address phase, strobes and data
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus_o <= '0;
      address_strobe_n_o <= 1'b1;
      data_strobe_n_o <= 1'b1;
      data_o <= 16'h0000;
      data_oe_o <= 1'b0;
      stop_cyc_reg <= 1'b0;
      shown_reg <= 1'b0;
      prefetch_reg <= 1'b0;
    end else if (ce_i) begin
      if (state_reg == BEC_IDLE && !stop_mode_o && state_next == BEC_ADDR) begin
        stop_cyc_reg <= stop_req_i;
        prefetch_reg <= !stop_req_i && req_i.prefetch;
        // A granted-away bus keeps the stop write internal
        shown_reg <= !(stop_req_i && bus_granted_away_i);
        address_strobe_n_o <= stop_req_i && bus_granted_away_i;
        if (stop_req_i) begin
          bus_o <= '{addr: `BEC_STOP_ADDR, fc: `BEC_CPU_SPACE_FC, write: 1'b1};
          data_o <= 16'h0000;
          data_o[`BEC_MASK_LSB +: 3] <= irq_mask_i;
          data_oe_o <= !bus_granted_away_i;
          // Fast write: data strobe stays idle
          data_strobe_n_o <= 1'b1;
        end else begin
          bus_o <= '{addr: req_i.addr, fc: req_i.fc, write: req_i.write};
          data_o <= req_i.wdata;
          data_oe_o <= req_i.write;
          data_strobe_n_o <= 1'b0;
        end
      end else if (cyc_end || state_next == BEC_DBL) begin
        // Address, code and direction stay put for a halted bus
        address_strobe_n_o <= 1'b1;
        data_strobe_n_o <= 1'b1;
        data_oe_o <= 1'b0;
        stop_cyc_reg <= 1'b0;
      end
    end
  end

  // Halt seen together with acknowledge at S
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      halt_s_reg <= 1'b0;
    end else if (ce_i && state_reg == BEC_WAIT) begin
      halt_s_reg <= halt_in;
    end
  end

  // ==========================================================
  // Cycle answer to the core
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_o <= 1'b0;
      done_bus_error_line_o <= 1'b0;
      rdata_o <= 16'h0000;
      ready_o <= 1'b1;
    end else if (ce_i) begin
      done_o <= cyc_end;
      done_bus_error_line_o <= end_bus_error_line;
      ready_o <= state_next == BEC_IDLE && !(stop_mode_o || stop_req_i);
      if (end_bus_error_line && prefetch_reg) begin
        rdata_o <= {2{`BEC_PRECHARGE_BYTE}};
      end else if ((end_ok || end_halt) && !bus_o.write) begin
        rdata_o <= data_i;
      end
    end
  end

  // ==========================================================
  // Bus error latch and exception request
  // The latch is set only at cycle end, so many errors in one
  // instruction still give one exception at its boundary
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus_error_line_latch_o <= 1'b0;
      bus_error_line_exc_o <= 1'b0;
    end else if (ce_i) begin
      bus_error_line_exc_o <= instr_done_i && (bus_error_line_latch_o || end_bus_error_line) && !exc_busy_reg;
      // A new error in the clearing cycle keeps the latch set
      if (end_bus_error_line) begin
        bus_error_line_latch_o <= 1'b1;
      end else if (handler_first_i) begin
        bus_error_line_latch_o <= 1'b0;
      end
    end
  end

  // Exception entry window and first instruction after reset
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      exc_busy_reg <= 1'b0;
      post_reset_reg <= 1'b1;
    end else if (ce_i) begin
      if (exc_start_i) begin
        exc_busy_reg <= 1'b1;
      end else if (handler_first_i) begin
        exc_busy_reg <= 1'b0;
      end
      if (instr_done_i) begin
        post_reset_reg <= 1'b0;
      end
    end
  end

  // Double fault: halt line pulled low until reset
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      double_fault_o <= 1'b0;
      halt_oe_o <= 1'b0;
    end else if (ce_i && end_bus_error_line && (exc_busy_reg || post_reset_reg)) begin
      double_fault_o <= 1'b1;
      halt_oe_o <= 1'b1;
    end
  end

  // ==========================================================
  // Low-power stop mode and the clock control mask copy
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stop_mode_o <= 1'b0;
      stop_mask_o <= `BEC_RESET_MASK;
    end else if (ce_i) begin
      if (state_reg == BEC_ADDR && stop_cyc_reg) begin
        stop_mode_o <= 1'b1;
        stop_mask_o <= data_o[`BEC_MASK_LSB +: 3];
      end else if (stop_mode_o && irq_level_i > stop_mask_o) begin
        stop_mode_o <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Checks
  sequence stop_addr_s;
    state_reg == BEC_ADDR && stop_cyc_reg;
  endsequence

  sequence stop_end_s;
    done_o && !done_bus_error_line_o && stop_mode_o;
  endsequence

  stop_addr_a: assert property (@(posedge clk_i) disable iff (!rstn_i || !ce_i)
    stop_addr_s |-> bus_o.addr == `BEC_STOP_ADDR && bus_o.fc == `BEC_CPU_SPACE_FC)
    else $error("stop write address wrong");

  stop_mask_a: assert property (@(posedge clk_i) disable iff (!rstn_i || !ce_i)
    stop_addr_s |=> stop_mask_o == $past(data_o[`BEC_MASK_LSB +: 3]))
    else $error("stop mask not captured");

  stop_hidden_a: assert property (@(posedge clk_i) disable iff (!rstn_i || !ce_i)
    stop_addr_s and !shown_reg |-> address_strobe_n_o && !data_oe_o)
    else $error("hidden stop write shown");

  stop_fast_a: assert property (@(posedge clk_i) disable iff (!rstn_i || !ce_i)
    stop_addr_s |=> stop_end_s)
    else $error("stop write not fast");

  stop_noberr_a: assert property (@(posedge clk_i) disable iff (!rstn_i || !ce_i)
    stop_addr_s ##1 done_o |-> !done_bus_error_line_o && !$rose(bus_error_line_latch_o))
    else $error("error seen in stop write");

  stop_wake_a: assert property (@(posedge clk_i) disable iff (!rstn_i || !ce_i)
    stop_mode_o && state_reg != BEC_ADDR && irq_level_i > stop_mask_o |=> !stop_mode_o)
    else $error("stop mode not left");

  bus_error_line_first_a: assert property (@(posedge clk_i) disable iff (!rstn_i || !ce_i)
    state_reg == BEC_WAIT && bus_error_line_in |=> done_o && done_bus_error_line_o && address_strobe_n_o)
    else $error("bus error not taken");

  normal_end_a: assert property (@(posedge clk_i) disable iff (!rstn_i || !ce_i)
    state_reg == BEC_WAIT && ack_in && !bus_error_line_in && !halt_in ##1 !bus_error_line_in
    |=> done_o && !done_bus_error_line_o && state_reg == BEC_IDLE)
    else $error("normal end missed");

  halt_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i || !ce_i)
    state_reg == BEC_HALT |-> address_strobe_n_o && data_strobe_n_o && !data_oe_o
    && $stable(bus_o))
    else $error("bus not parked in halt");

  bus_error_line_latch_a: assert property (@(posedge clk_i) disable iff (!rstn_i || !ce_i)
    handler_first_i && !end_bus_error_line |=> !bus_error_line_latch_o)
    else $error("error latch not cleared");

  dbl_halt_a: assert property (@(posedge clk_i) disable iff (!rstn_i || !ce_i)
    end_bus_error_line && exc_busy_reg |=> double_fault_o && halt_oe_o && state_reg == BEC_DBL
    ##1 state_reg == BEC_DBL [*2])
    else $error("double fault not halted");

  monitor_a: assert property (@(posedge clk_i) disable iff (!rstn_i || !ce_i)
    state_reg == BEC_WAIT && mon_timeout && !stop_cyc_reg |=> done_bus_error_line_o)
    else $error("monitor timeout ignored");
endmodule

// ==== testbench/bec_term_model.sv ====
// ==========================================================
// Far-side responder: acknowledge, bus error, halt and read data
module bec_term_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic address_strobe_n_i,
  input wire logic [2:0] mode_i,
  input wire logic [3:0] delay_i,
  input wire logic [15:0] rdata_i,
  output logic [1:0] data_size_ack_n_o,
  output logic bus_error_line_n_o,
  output logic halt_n_o,
  output logic [15:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Modes: 0 ack, 1 error at S, 2 ack with held halt, 3 ack then error and halt,
  // 4 silent, 5 ack then late halt only
  logic [3:0] cnt_reg;
  wire logic hit = !address_strobe_n_i && (cnt_reg == delay_i);
  wire logic late = !address_strobe_n_i && (cnt_reg == delay_i + 4'h1);

  // ==========================================================
  // Lines change only on the rising edge, and stay asserted until strobe ends
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= 4'h0;
      data_size_ack_n_o <= 2'h3;
      bus_error_line_n_o <= 1'b1;
      halt_n_o <= 1'b1;
      data_o <= 16'h0000;
    end else begin
      cnt_reg <= address_strobe_n_i ? 4'h0 : cnt_reg + 4'h1;
      if (address_strobe_n_i) begin
        data_size_ack_n_o <= 2'h3;
        bus_error_line_n_o <= 1'b1;
        data_o <= ~data_o; // Released bus alternates between the last value and its inverse every clock
        if (mode_i != 3'h2) begin
          halt_n_o <= 1'b1; // Held halt is let go only when the bench says so
        end
      end else begin
        data_o <= rdata_i;
        if (hit && mode_i != 3'h1 && mode_i != 3'h4) begin
          data_size_ack_n_o <= 2'h0;
        end
        if ((hit && mode_i == 3'h1) || (late && mode_i == 3'h3)) begin
          bus_error_line_n_o <= 1'b0;
        end
        if ((hit && mode_i == 3'h2) || (late && (mode_i == 3'h3 || mode_i == 3'h5))) begin
          halt_n_o <= 1'b0;
        end
      end
    end
  end
endmodule

// ==== testbench/bec_exception_ctrl_bench.sv ====
module bec_exception_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import bec_pkg::*;
  logic clk_i, rstn_i, ce_i, req_valid_i, stop_req_i, bus_granted_away_i, iack_no_arb_i;
  logic instr_done_i, exc_start_i, handler_first_i, bus_monitor_en_i, autovector_request_n_i;
  logic [2:0] irq_mask_i, irq_level_i, mode, stop_mask_o;
  logic [1:0] bus_monitor_timeout_field_i, data_size_ack_n_i;
  logic [3:0] delay;
  logic [15:0] data_i, pdata, data_o, rdata_o;
  logic bus_error_line_n_i, ext_halt_n, address_strobe_n_o, data_strobe_n_o, data_oe_o;
  logic halt_n_o, halt_oe_o, ready_o, done_o, done_bus_error_line_o, bus_error_line_latch_o, bus_error_line_exc_o;
  logic stop_mode_o, double_fault_o;
  bec_req_t req_i;
  bec_bus_t bus_o;
  int fail_count = 0;
  int comparisons = 0;
  // Open-drain halt: low when either party pulls it
  wire logic halt_n_i = ext_halt_n & ~(halt_oe_o & ~halt_n_o);

  bec_exception_ctrl i_bec_exception_ctrl (.*);
  bec_term_model i_bec_term_model (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .address_strobe_n_i(address_strobe_n_o),
    .mode_i(mode),
    .delay_i(delay),
    .rdata_i(pdata),
    .data_size_ack_n_o(data_size_ack_n_i),
    .bus_error_line_n_o(bus_error_line_n_i),
    .halt_n_o(ext_halt_n),
    .data_o(data_i)
  );

  // ==========================================================
  // Clock, checking and closing
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("Compares %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic do_reset();
    rstn_i = 1'b0;
    repeat (20) @(negedge clk_i);
    rstn_i = 1'b1;
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk_i);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
  endtask

  // One read cycle; returns at the sample where done_o is high
  task automatic run_cycle(input logic [19:0] a, input logic pf, output logic eb,
                           output logic [15:0] rd, output int lat);
    int n;
    @(negedge clk_i);
    req_i = '{addr: a, fc: 3'h5, write: 1'b0, prefetch: pf, wdata: 16'h0000};
    req_valid_i = 1'b1;
    @(negedge clk_i);
    req_valid_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 200) check(n, 0);
    eb = done_bus_error_line_o;
    rd = rdata_o;
    lat = n;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_read();
    logic eb;
    logic [15:0] rd;
    int lat;
    mode = 3'h0;
    delay = 4'h2;
    pdata = 16'hA5C3;
    run_cycle(20'h1_2344, 1'b0, eb, rd, lat);
    check(eb, 1'b0);
    check(lat, 5);
    check(rd, 16'hA5C3);
    mode = 3'h5;
    pdata = 16'h3C5A;
    run_cycle(20'h1_2346, 1'b0, eb, rd, lat);
    check({eb, ready_o}, 2'h1);
    check(rd, 16'h3C5A);
    // Silent responder; the autovector line alone must end the cycle
    mode = 3'h4;
    autovector_request_n_i = 1'b0;
    run_cycle(20'h1_2348, 1'b0, eb, rd, lat);
    autovector_request_n_i = 1'b1;
    check(eb, 1'b0);
    check(lat, 3);
    check(rd, 16'h3C5A);
    $display("read test done");
  endtask

  task automatic t_halt();
    logic eb;
    logic [15:0] rd;
    int lat;
    mode = 3'h2;
    run_cycle(20'h0_4440, 1'b0, eb, rd, lat);
    check({eb, ready_o}, 2'h0);
    repeat (3) @(negedge clk_i);
    check({address_strobe_n_o, data_strobe_n_o, data_oe_o, ready_o}, 4'hC);
    check(bus_o.addr, 20'h0_4440);
    mode = 3'h0;
    repeat (4) @(negedge clk_i);
    check(ready_o, 1'b1);
    $display("halt test done");
  endtask

  task automatic t_bus_error_line();
    logic eb;
    logic [15:0] rd;
    int lat;
    int n;
    mode = 3'h1;
    delay = 4'h1;
    run_cycle(20'h0_0100, 1'b1, eb, rd, lat);
    check(eb, 1'b1);
    check(rd, 16'hFFFF);
    mode = 3'h3;
    run_cycle(20'h0_0102, 1'b0, eb, rd, lat);
    check(eb, 1'b1);
    @(negedge clk_i);
    check({bus_error_line_latch_o, bus_error_line_exc_o}, 2'h2);
    n = 0;
    instr_done_i = 1'b1;
    repeat (6) begin
      @(negedge clk_i);
      instr_done_i = 1'b0;
      n += int'(bus_error_line_exc_o);
    end
    check(n, 1);
    pulse(exc_start_i);
    pulse(handler_first_i);
    @(negedge clk_i);
    check({bus_error_line_latch_o, double_fault_o}, 2'h0);
    mode = 3'h1;
    run_cycle(20'h0_0104, 1'b0, eb, rd, lat);
    @(negedge clk_i);
    check({eb, bus_error_line_latch_o, double_fault_o}, 3'h6);
    $display("bus error test done");
  endtask

  task automatic t_monitor();
    logic eb;
    logic [15:0] rd;
    int lat;
    int p;
    mode = 3'h4;
    bus_monitor_en_i = 1'b1;
    for (int f = 0; f < 4; f++) begin
      bus_monitor_timeout_field_i = f[1:0];
      p = 8 << f;
      run_cycle(20'h0_8000, 1'b0, eb, rd, lat);
      check(eb, 1'b1);
      check(lat >= p - 1 && lat <= p + 4, 1'b1);
    end
    bus_monitor_en_i = 1'b0;
    iack_no_arb_i = 1'b1;
    run_cycle(20'h0_8002, 1'b0, eb, rd, lat);
    iack_no_arb_i = 1'b0;
    check(eb, 1'b1);
    $display("monitor test done");
  endtask

  task automatic t_stop(input logic away);
    mode = 3'h1;
    delay = 4'h0;
    bus_granted_away_i = away;
    irq_level_i = 3'h0;
    @(negedge clk_i);
    irq_mask_i = 3'h5;
    stop_req_i = 1'b1;
    @(negedge clk_i);
    stop_req_i = 1'b0;
    check(address_strobe_n_o, away);
    check({bus_o.addr, bus_o.fc}, {20'h3_FFFE, 3'h7});
    check({data_o, data_oe_o}, {16'h0500, !away});
    @(negedge clk_i);
    check({done_o, done_bus_error_line_o}, 2'h2);
    check({stop_mode_o, stop_mask_o}, 4'hD);
    req_valid_i = 1'b1;
    irq_level_i = 3'h5;
    repeat (3) @(negedge clk_i);
    check({stop_mode_o, address_strobe_n_o}, 2'h3);
    req_valid_i = 1'b0;
    irq_level_i = 3'h6;
    repeat (3) @(negedge clk_i);
    check(stop_mode_o, 1'b0);
    bus_granted_away_i = 1'b0;
    $display("stop test done");
  endtask

  task automatic t_double();
    logic eb;
    logic [15:0] rd;
    int lat;
    pulse(exc_start_i);
    mode = 3'h1;
    run_cycle(20'h0_0200, 1'b0, eb, rd, lat);
    @(negedge clk_i);
    check({double_fault_o, halt_oe_o, halt_n_o}, 3'h6);
    req_valid_i = 1'b1;
    repeat (4) @(negedge clk_i);
    check(address_strobe_n_o, 1'b1);
    req_valid_i = 1'b0;
    do_reset();
    check({double_fault_o, stop_mask_o, ready_o}, 5'h0F);
    run_cycle(20'h0_0202, 1'b0, eb, rd, lat);
    @(negedge clk_i);
    check(double_fault_o, 1'b1);
    do_reset();
    $display("double fault test done");
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    rstn_i = 1'b0;
    ce_i = 1'b1;
    autovector_request_n_i = 1'b1;
    {req_valid_i, stop_req_i, bus_granted_away_i, iack_no_arb_i} = 4'h0;
    {instr_done_i, exc_start_i, handler_first_i, bus_monitor_en_i} = 4'h0;
    {irq_mask_i, irq_level_i, bus_monitor_timeout_field_i} = 8'h00;
    req_i = '0;
    mode = 3'h0;
    delay = 4'h1;
    pdata = 16'h0000;
    do_reset();
    check({address_strobe_n_o, ready_o, halt_oe_o, stop_mask_o}, 6'h37);
    pulse(instr_done_i); // Closes the window after reset
    t_read();
    t_halt();
    t_bus_error_line();
    t_monitor();
    t_stop(1'b0);
    t_stop(1'b1);
    t_double();
    close_out();
  end

  // Whole run is well under a thousand cycles; this is twenty times that
  initial begin
    #100000;
    fail_count++;
    $display("watchdog expired");
    close_out();
  end
endmodule
